/* srnvp_pkg.sv */
package srnvp_pkg;

  // Instruction codes that reach this register
  localparam logic [7:0] SRNVP_CMD_WRITE_REGS = 8'h01;
  localparam logic [7:0] SRNVP_CMD_READ_ANY = 8'h65;
  localparam logic [7:0] SRNVP_CMD_WRITE_ANY = 8'h71;

  // Register selects for read-any / write-any
  localparam logic [2:0] SRNVP_SEL_STATUS_STORED = 3'h0;
  localparam logic [2:0] SRNVP_SEL_STATUS_LIVE = 3'h1;
  localparam logic [2:0] SRNVP_SEL_CONFIG_STORED = 3'h2;
  localparam logic [2:0] SRNVP_SEL_CONFIG_LIVE = 3'h3;

  // Field positions in the status registers
  localparam int SRNVP_WD_BIT = 7;
  localparam int SRNVP_PERR_BIT = 6;
  localparam int SRNVP_EERR_BIT = 5;
  localparam int SRNVP_BP_HI = 4;
  localparam int SRNVP_BP_LO = 2;
  localparam int SRNVP_WEL_BIT = 1;
  localparam int SRNVP_BUSY_BIT = 0;
  // Protection-select bit of the configuration register
  localparam int SRNVP_CFG_SEL_BIT = 3;

  // As-shipped contents and forced values
  localparam logic [7:0] SRNVP_STATUS_STORED_RST = 8'h00;
  localparam logic [7:0] SRNVP_CONFIG_STORED_RST = 8'h00;
  localparam logic [2:0] SRNVP_BP_LOCKED = 3'h7;
  localparam logic [7:0] SRNVP_ZERO_BYTE = 8'h00;
  // Pin level assumed before the synchroniser fills
  localparam logic SRNVP_WP_IDLE = 1'b1;

  // Array operations checked against block protection
  typedef enum logic [1:0] {
    SRNVP_OP_PROGRAM = 2'h0,
    SRNVP_OP_SECTOR_ERASE = 2'h1,
    SRNVP_OP_WHOLE_ERASE = 2'h2
  } srnvp_op_kind_t;

  // Decoded register command from the serial front end
  typedef struct packed {
    logic valid;
    logic [7:0] code;
    logic [2:0] sel;
    logic has_cfg;
    logic [7:0] data0;
    logic [7:0] data1;
  } srnvp_cmd_t;

  // Program or erase request
  typedef struct packed {
    logic valid;
    srnvp_op_kind_t kind;
    logic [23:0] addr;
  } srnvp_op_t;

endpackage

/* srnvp_sync2.sv */
`timescale 1ns/1ps
module srnvp_sync2
  import srnvp_pkg::*;
#(
  parameter int W = 1
)(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Asynchronous level in, synchronised level out
  input wire logic [W-1:0] i_async,
  output logic [W-1:0] o_sync
);

  logic [W-1:0] stage1_reg;
  logic [W-1:0] stage2_reg;

  // Two flops; only the second stage is visible to logic
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      stage1_reg <= {W{SRNVP_WP_IDLE}};
      stage2_reg <= {W{SRNVP_WP_IDLE}};
    end
    else
    begin
      stage1_reg <= i_async;
      stage2_reg <= stage1_reg;
    end
  end

  assign o_sync = stage2_reg;

endmodule

/* srnvp_area.sv */
`timescale 1ns/1ps
module srnvp_area
  import srnvp_pkg::*;
#(
  parameter int ADDR_W = 24
)(
  // Active protect code and target address
  input wire logic [2:0] i_bp,
  input wire logic [ADDR_W-1:0] i_addr,
  // Address falls in the protected area
  output logic o_hit
);

  // Protected part grows from the top of the array in 64ths
  logic [6:0] span;
  logic [6:0] floor_64th;
  logic [6:0] addr_64th;

  assign span = (i_bp == 3'h0) ? 7'h00 : (7'h01 << (i_bp - 3'h1));
  assign floor_64th = 7'h40 - span;
  assign addr_64th = {1'b0, i_addr[ADDR_W-1 -: 6]};
  assign o_hit = (i_bp != 3'h0) && (addr_64th >= floor_64th);

endmodule

/* srnvp_top.sv */
// Summary of operation
// - Decode write-regs, read-any, write-any instruction codes
// - Hardware protect: stored disable set, pin low
// - Hardware protect discards status/config register writes
// - Pin high allows status/config writes
// - Stored disable clear: pin ignored
// - Pin never gates other register writes
// - Live bit 7 mirrors stored disable
// - Stored bit 6 seeds program-error, read-only
// - Stored bit 5 seeds erase-error, read-only
// - Stored bit 1 seeds write latch, fixed
// - Stored bit 0 seeds busy flag, fixed
// - Select 0: write stores field, copies live
// - Select 1: write updates live field only
// - Going volatile forces stored field to ones
// - Protected area refuses program and erase
// - Whole erase only when active field zero
// - Reset reloads live copies from stored
// - Stored write refreshes the live copy
`timescale 1ns/1ps
module srnvp_top
  import srnvp_pkg::*;
#(
  parameter int ADDR_W = 24,
  parameter logic [7:0] STATUS_STORED_INIT = SRNVP_STATUS_STORED_RST,
  parameter logic [7:0] CONFIG_STORED_INIT = SRNVP_CONFIG_STORED_RST
)(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Hardware or software reset request, one-cycle pulse
  input wire logic i_reload,
  // Write-protect pin, active low
  input wire logic i_wp_n,
  // Register command
  input wire srnvp_cmd_t i_cmd,
  output logic o_cmd_ready,
  // Command answer
  output logic o_cmd_done,
  output logic o_cmd_discard,
  output logic o_other_write,
  output logic [7:0] o_rd_data,
  // Array operation check
  input wire srnvp_op_t i_op,
  output logic o_op_grant,
  output logic o_op_refuse,
  // Register contents
  output logic [7:0] o_status_stored,
  output logic [7:0] o_status_live,
  output logic [7:0] o_config_live,
  output logic o_hw_protect
);

  typedef enum logic [1:0] {
    SRNVP_ST_IDLE = 2'b01,
    SRNVP_ST_EXEC = 2'b10
  } srnvp_state_t;

  srnvp_state_t state_reg;
  srnvp_state_t state_next;
  srnvp_cmd_t cmd_reg;

  logic [7:0] status_one_stored_reg;
  logic [7:0] status_one_live_reg;
  logic [7:0] config_one_stored_reg;
  logic [7:0] config_one_live_reg;
  logic cmd_done_reg;
  logic cmd_discard_reg;
  logic other_write_reg;
  logic [7:0] rd_data_reg;
  logic op_grant_reg;
  logic op_refuse_reg;

  logic wp_n_sync;
  logic stored_write_disable;
  logic protect_select;
  logic hw_protect;
  logic [2:0] active_bp;
  logic area_hit;

  // Pin crosses into the clock domain before use
  srnvp_sync2 #(
    .W(1)
  ) u_wp_sync (
    .i_clk(i_clk),
    .i_nrst(i_nrst),
    .i_async(i_wp_n),
    .o_sync(wp_n_sync)
  );

  // Protection state
  assign stored_write_disable = status_one_stored_reg[SRNVP_WD_BIT];
  assign protect_select = config_one_stored_reg[SRNVP_CFG_SEL_BIT];
  assign hw_protect = stored_write_disable & ~wp_n_sync;
  assign active_bp = protect_select ?
    status_one_live_reg[SRNVP_BP_HI:SRNVP_BP_LO] :
    status_one_stored_reg[SRNVP_BP_HI:SRNVP_BP_LO];

  // Address range decode of the active protect field
  srnvp_area #(
    .ADDR_W(ADDR_W)
  ) u_area (
    .i_bp(active_bp),
    .i_addr(i_op.addr[ADDR_W-1:0]),
    .o_hit(area_hit)
  );

  // Command decode of the captured request
  logic is_wrr;
  logic is_read_any_register_cmd;
  logic is_write_any_register_cmd;
  logic sel_ours;
  logic wr_ours;
  logic wr_other;
  logic wr_blocked;
  logic wr_go;

  assign is_wrr = (cmd_reg.code == SRNVP_CMD_WRITE_REGS);
  assign is_read_any_register_cmd = (cmd_reg.code == SRNVP_CMD_READ_ANY);
  assign is_write_any_register_cmd = (cmd_reg.code == SRNVP_CMD_WRITE_ANY);
  assign sel_ours = (cmd_reg.sel <= SRNVP_SEL_CONFIG_LIVE);
  assign wr_ours = is_wrr | (is_write_any_register_cmd & sel_ours);
  assign wr_other = is_write_any_register_cmd & ~sel_ours;
  // Evaluated at execution so a late pin change still counts
  assign wr_blocked = wr_ours & hw_protect;
  assign wr_go = (state_reg == SRNVP_ST_EXEC) & wr_ours & ~wr_blocked;

  // Which register the write lands in
  logic hit_status_stored;
  logic hit_status_live;
  logic hit_config_stored;
  logic hit_config_live;

  assign hit_status_stored = wr_go &
    (is_wrr | (cmd_reg.sel == SRNVP_SEL_STATUS_STORED));
  assign hit_status_live = wr_go & is_write_any_register_cmd &
    (cmd_reg.sel == SRNVP_SEL_STATUS_LIVE);
  assign hit_config_stored = wr_go &
    ((is_wrr & cmd_reg.has_cfg) | (is_write_any_register_cmd & (cmd_reg.sel == SRNVP_SEL_CONFIG_STORED)));
  assign hit_config_live = wr_go & is_write_any_register_cmd &
    (cmd_reg.sel == SRNVP_SEL_CONFIG_LIVE);

  // Byte written to the status register, either via write-regs or write-any
  logic [7:0] status_byte;
  logic [7:0] config_byte;
  logic [2:0] new_bp;
  logic bp_stored_open;
  logic going_volatile;

  assign status_byte = is_wrr ? cmd_reg.data0 : cmd_reg.data0;
  assign config_byte = is_wrr ? cmd_reg.data1 : cmd_reg.data0;
  assign new_bp = status_byte[SRNVP_BP_HI:SRNVP_BP_LO];
  // Field stays user-programmable only while selection is stored
  assign bp_stored_open = ~protect_select;
  // Selection is one-way: once volatile it cannot return
  assign going_volatile = hit_config_stored & ~protect_select &
    config_byte[SRNVP_CFG_SEL_BIT];

  // Next stored status: only the disable bit and protect field are writable
  logic [7:0] status_stored_next;
  always_comb
  begin
    status_stored_next = status_one_stored_reg;
    if (hit_status_stored)
    begin
      status_stored_next[SRNVP_WD_BIT] = status_byte[SRNVP_WD_BIT];
      if (bp_stored_open & ~is_wrr)
        status_stored_next[SRNVP_BP_HI:SRNVP_BP_LO] = new_bp;
      if (bp_stored_open & is_wrr)
        status_stored_next[SRNVP_BP_HI:SRNVP_BP_LO] = new_bp;
      // Default bits 6,5,1,0 keep their stored values
      status_stored_next[SRNVP_PERR_BIT] = status_one_stored_reg[SRNVP_PERR_BIT];
      status_stored_next[SRNVP_EERR_BIT] = status_one_stored_reg[SRNVP_EERR_BIT];
      status_stored_next[SRNVP_WEL_BIT] = status_one_stored_reg[SRNVP_WEL_BIT];
      status_stored_next[SRNVP_BUSY_BIT] = status_one_stored_reg[SRNVP_BUSY_BIT];
    end
    if (going_volatile)
      status_stored_next[SRNVP_BP_HI:SRNVP_BP_LO] = SRNVP_BP_LOCKED;
  end

  // Next stored configuration: the select bit can only be set
  logic [7:0] config_stored_next;
  always_comb
  begin
    config_stored_next = config_one_stored_reg;
    if (hit_config_stored)
    begin
      config_stored_next = config_byte;
      config_stored_next[SRNVP_CFG_SEL_BIT] = protect_select |
        config_byte[SRNVP_CFG_SEL_BIT];
    end
  end

  // Next live status
  logic [7:0] status_live_next;
  always_comb
  begin
    status_live_next = status_one_live_reg;
    if (i_reload)
      status_live_next = status_one_stored_reg;
    else
    begin
      // Stored rewrite refreshes disable and, when stored, protect field
      status_live_next[SRNVP_WD_BIT] = status_stored_next[SRNVP_WD_BIT];
      if (~protect_select & ~going_volatile)
        status_live_next[SRNVP_BP_HI:SRNVP_BP_LO] =
          status_stored_next[SRNVP_BP_HI:SRNVP_BP_LO];
      // Switching to volatile must not copy the forced ones into the live field
      if (~protect_select & going_volatile & hit_status_stored)
        status_live_next[SRNVP_BP_HI:SRNVP_BP_LO] = new_bp;
      if (protect_select & (hit_status_live | (hit_status_stored & is_wrr)))
        status_live_next[SRNVP_BP_HI:SRNVP_BP_LO] = new_bp;
    end
  end

  // Next live configuration
  logic [7:0] config_live_next;
  always_comb
  begin
    config_live_next = config_one_live_reg;
    if (i_reload | hit_config_stored)
      config_live_next = config_stored_next;
    else if (hit_config_live)
    begin
      config_live_next = cmd_reg.data0;
      // Selection lives only in the stored copy
      config_live_next[SRNVP_CFG_SEL_BIT] = protect_select;
    end
  end

  // Read-any data select
  logic [7:0] rd_sel_data;
  always_comb
  begin
    rd_sel_data = SRNVP_ZERO_BYTE;
    unique case (cmd_reg.sel)
      SRNVP_SEL_STATUS_STORED: rd_sel_data = status_one_stored_reg;
      SRNVP_SEL_STATUS_LIVE: rd_sel_data = status_one_live_reg;
      SRNVP_SEL_CONFIG_STORED: rd_sel_data = config_one_stored_reg;
      SRNVP_SEL_CONFIG_LIVE: rd_sel_data = config_one_live_reg;
      default: rd_sel_data = SRNVP_ZERO_BYTE;
    endcase
  end

  // Command sequencer: capture, then execute
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      SRNVP_ST_IDLE:
        if (i_cmd.valid)
          state_next = SRNVP_ST_EXEC;
      SRNVP_ST_EXEC:
        state_next = SRNVP_ST_IDLE;
      default:
        state_next = SRNVP_ST_IDLE;
    endcase
  end

  assign o_cmd_ready = (state_reg == SRNVP_ST_IDLE);

  // Array operation verdict
  logic op_ok;
  assign op_ok = (i_op.kind == SRNVP_OP_WHOLE_ERASE) ?
    (active_bp == 3'h0) :
    ~area_hit;

  // Sequencer and command capture
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      state_reg <= SRNVP_ST_IDLE;
      cmd_reg <= '0;
    end
    else
    begin
      state_reg <= state_next;
      if (o_cmd_ready & i_cmd.valid)
        cmd_reg <= i_cmd;
    end
  end

  // Stored registers; power-on gives the as-shipped contents
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      status_one_stored_reg <= STATUS_STORED_INIT;
      config_one_stored_reg <= CONFIG_STORED_INIT;
    end
    else
    begin
      status_one_stored_reg <= status_stored_next;
      config_one_stored_reg <= config_stored_next;
    end
  end

  // Live registers; power-on loads them from the stored values
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      status_one_live_reg <= STATUS_STORED_INIT;
      config_one_live_reg <= CONFIG_STORED_INIT;
    end
    else
    begin
      status_one_live_reg <= status_live_next;
      config_one_live_reg <= config_live_next;
    end
  end

  // Command answer flags, one-cycle pulses
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      cmd_done_reg <= 1'b0;
      cmd_discard_reg <= 1'b0;
      other_write_reg <= 1'b0;
      rd_data_reg <= SRNVP_ZERO_BYTE;
    end
    else
    begin
      cmd_done_reg <= (state_reg == SRNVP_ST_EXEC);
      cmd_discard_reg <= (state_reg == SRNVP_ST_EXEC) & wr_blocked;
      other_write_reg <= (state_reg == SRNVP_ST_EXEC) & wr_other;
      if ((state_reg == SRNVP_ST_EXEC) & is_read_any_register_cmd)
        rd_data_reg <= rd_sel_data;
    end
  end

  // Operation verdict, one cycle after the request
  always_ff @(posedge i_clk or negedge i_nrst)
  begin
    if (!i_nrst)
    begin
      op_grant_reg <= 1'b0;
      op_refuse_reg <= 1'b0;
    end
    else
    begin
      op_grant_reg <= i_op.valid & op_ok;
      op_refuse_reg <= i_op.valid & ~op_ok;
    end
  end

  // Outputs
  assign o_cmd_done = cmd_done_reg;
  assign o_cmd_discard = cmd_discard_reg;
  assign o_other_write = other_write_reg;
  assign o_rd_data = rd_data_reg;
  assign o_op_grant = op_grant_reg;
  assign o_op_refuse = op_refuse_reg;
  assign o_status_stored = status_one_stored_reg;
  assign o_status_live = status_one_live_reg;
  assign o_config_live = config_one_live_reg;
  assign o_hw_protect = hw_protect;

endmodule

/* srnvp_monitor.sv */
`timescale 1ns/1ps
module srnvp_monitor
  import srnvp_pkg::*;
(
  // Clock and reset
  input wire logic i_clk,
  input wire logic i_nrst,
  // Requests
  input wire logic i_reload,
  input wire logic i_wp_n,
  input wire srnvp_cmd_t i_cmd,
  input wire srnvp_op_t i_op,
  // Answers
  input wire logic o_cmd_ready,
  input wire logic o_cmd_done,
  input wire logic o_cmd_discard,
  input wire logic o_other_write,
  input wire logic o_op_grant,
  input wire logic o_op_refuse,
  // Register contents
  input wire logic [7:0] o_status_stored,
  input wire logic [7:0] o_status_live,
  input wire logic [7:0] o_config_live,
  input wire logic o_hw_protect
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_nrst);
  logic [1:0] up_reg;
  // Field that currently governs protection
  wire logic [2:0] act_bp = o_config_live[3] ? o_status_live[4:2] : o_status_stored[4:2];
  wire logic is_wr = i_cmd.code == 8'h01 || (i_cmd.code == 8'h71 && !i_cmd.sel[2]);

  // Edges since reset; the pin synchroniser is not trusted until it has filled
  always_ff @(posedge i_clk or negedge i_nrst)
    if (!i_nrst)
      up_reg <= 2'h0;
    else if (up_reg != 2'h2)
      up_reg <= up_reg + 2'h1;

  sequence s_take;
    i_cmd.valid && o_cmd_ready;
  endsequence
  sequence s_take_wr;
    s_take ##0 is_wr;
  endsequence

  property p_done_lat;
    s_take |=> !o_cmd_ready ##1 o_cmd_done;
  endproperty
  a_done_lat: assert property (p_done_lat) else $error("done not two cycles after take");
  property p_hw;
    up_reg == 2'h2 |-> o_hw_protect == (o_status_stored[7] && !$past(i_wp_n, 2));
  endproperty
  a_hw: assert property (p_hw) else $error("protect mode wrong");
  property p_gate;
    s_take_wr ##1 1'b1 |=> o_cmd_discard == $past(o_hw_protect);
  endproperty
  a_gate: assert property (p_gate) else $error("discard disagrees with protect");
  property p_frozen;
    o_cmd_discard && !i_reload |=> $stable(o_status_stored) && $stable(o_status_live)
      && $stable(o_config_live);
  endproperty
  a_frozen: assert property (p_frozen) else $error("discarded write changed a register");
  property p_other;
    s_take ##0 (i_cmd.code == 8'h71 && i_cmd.sel[2]) |-> ##2 o_other_write && !o_cmd_discard;
  endproperty
  a_other: assert property (p_other) else $error("foreign write mishandled");
  property p_mirror;
    o_status_live[7] == o_status_stored[7];
  endproperty
  a_mirror: assert property (p_mirror) else $error("live disable bit differs");
  property p_fixed;
    $stable({o_status_stored[6:5], o_status_stored[1:0]});
  endproperty
  a_fixed: assert property (p_fixed) else $error("default bit changed");
  property p_bp_copy;
    !o_config_live[3] |-> o_status_live[4:2] == o_status_stored[4:2];
  endproperty
  a_bp_copy: assert property (p_bp_copy) else $error("live field not a copy");
  property p_bp_lock;
    o_config_live[3] |-> o_status_stored[4:2] == SRNVP_BP_LOCKED;
  endproperty
  a_bp_lock: assert property (p_bp_lock) else $error("stored field not locked");
  property p_whole;
    i_op.valid && i_op.kind == SRNVP_OP_WHOLE_ERASE |=>
      o_op_refuse == ($past(act_bp) != 3'h0) && o_op_grant == !o_op_refuse;
  endproperty
  a_whole: assert property (p_whole) else $error("whole erase answer wrong");
  property p_reload;
    i_reload |=> o_status_live == $past(o_status_stored);
  endproperty
  a_reload: assert property (p_reload) else $error("reload did not copy");
endmodule

bind srnvp_top srnvp_monitor u_mon (.i_clk, .i_nrst, .i_reload, .i_wp_n, .i_cmd, .i_op,
  .o_cmd_ready, .o_cmd_done, .o_cmd_discard, .o_other_write, .o_op_grant, .o_op_refuse,
  .o_status_stored, .o_status_live, .o_config_live, .o_hw_protect);

/* srnvp_host.sv */
`timescale 1ns/1ps
module srnvp_host
  import srnvp_pkg::*;
(
  // Clock and handshake
  input wire logic i_clk,
  input wire logic i_ready,
  // Command towards the device
  output srnvp_cmd_t o_cmd
);
  initial o_cmd = '0;

  // One command; lag idles first so prompt and slow hosts both appear
  task automatic send(input srnvp_cmd_t c, input int lag);
    repeat (lag) @(posedge i_clk);
    @(posedge i_clk);
    c.valid = 1'b1;
    o_cmd <= c;
    @(posedge i_clk);
    while (i_ready !== 1'b1) @(posedge i_clk);
    // Released fields carry the inverse, so a late sampler is caught
    o_cmd <= ~c;
  endtask
endmodule

/* status_reg1_nonvolatile_protect_tb.sv */
`timescale 1ns/1ps
module status_reg1_nonvolatile_protect_tb;
  import srnvp_pkg::*;
  logic i_clk = 1'b0;
  logic i_nrst = 1'b0;
  logic i_reload = 1'b0;
  logic i_wp_n = 1'b1;
  srnvp_cmd_t i_cmd;
  srnvp_op_t i_op = '0;
  logic o_cmd_ready, o_cmd_done, o_cmd_discard, o_other_write;
  logic o_op_grant, o_op_refuse, o_hw_protect;
  logic [7:0] o_rd_data, o_status_stored, o_status_live, o_config_live;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  int seed = 78;
  int st, lv, cf, cl, rd;
  int codes[4] = '{8'h01, 8'h65, 8'h71, 8'h3C};

  always #12.5 i_clk = ~i_clk;

  srnvp_host host (.i_clk, .i_ready(o_cmd_ready), .o_cmd(i_cmd));
  srnvp_top dut (.i_clk, .i_nrst, .i_reload, .i_wp_n, .i_cmd, .o_cmd_ready, .o_cmd_done,
    .o_cmd_discard, .o_other_write, .o_rd_data, .i_op, .o_op_grant, .o_op_refuse,
    .o_status_stored, .o_status_live, .o_config_live, .o_hw_protect);

  function automatic int rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed & 32'h7FFFFFFF;
  endfunction

  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    checked++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("wrong value %s expected %h seen %h", nm, exp, seen);
    end
  endtask

  task automatic results();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  // A hang ends the run as a failure
  always @(posedge i_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      results();
    end
  end

  // Stored status write: default bits keep, field moves only while select is clear
  task automatic wr_st(input int d);
    st = (st & (cf[3] ? 8'h7F : 8'h63)) | (d & (cf[3] ? 8'h80 : 8'h9C));
    lv = cf[3] ? ((lv & 8'h7F) | (st & 8'h80)) : ((lv & 8'h63) | (st & 8'h9C));
  endtask
  task automatic wr_lbp(input int d);
    if (cf[3]) lv = (lv & 8'hE3) | (d & 8'h1C);
  endtask
  // Select bit can only be set, and setting it locks the stored field
  task automatic wr_cf(input int d);
    cf = d | (cf & 8'h08);
    if (cf[3]) st = st | 8'h1C;
    cl = cf;
  endtask

  task automatic cmd(input int code, input int sel, input int d0, input int d1, input bit hc);
    srnvp_cmd_t c;
    bit hw, dis, oth;
    c = '{1'b1, 8'(code), 3'(sel), hc, 8'(d0), 8'(d1)};
    hw = st[7] && !i_wp_n;
    chk("hw", {7'h0, o_hw_protect}, {7'h0, hw});
    dis = hw && (code == 8'h01 || (code == 8'h71 && sel < 4));
    oth = code == 8'h71 && sel >= 4;
    if (code == 8'h01 && !hw)
    begin
      wr_st(d0);
      wr_lbp(d0);
      if (hc) wr_cf(d1);
    end
    else if (code == 8'h71 && !hw)
      case (sel)
        0: wr_st(d0);
        1: wr_lbp(d0);
        2: wr_cf(d0);
        3: cl = (d0 & 8'hF7) | (cf & 8'h08);
        default: ;
      endcase
    else if (code == 8'h65)
      rd = sel == 0 ? st : sel == 1 ? lv : sel == 2 ? cf : sel == 3 ? cl : 0;
    host.send(c, rnd() & 3);
    // Send returns at the taking edge; the answer pulse stands for the next cycle only
    @(posedge i_clk);
    #1;
    chk("flags", {5'h0, o_cmd_done, o_cmd_discard, o_other_write}, {5'h0, 1'b1, dis, oth});
    chk("stored", o_status_stored, 8'(st));
    chk("live", o_status_live, 8'(lv));
    chk("config", o_config_live, 8'(cl));
    chk("read", o_rd_data, 8'(rd));
  endtask

  task automatic op(input int kind, input int addr);
    int bp;
    bit prot;
    bp = cf[3] ? (lv >> 2) & 7 : (st >> 2) & 7;
    prot = bp != 0 && (kind == 2 || ((addr >> 18) & 63) >= 64 - (1 << (bp - 1)));
    @(posedge i_clk);
    i_op <= '{1'b1, srnvp_op_kind_t'(kind), 24'(addr)};
    @(posedge i_clk);
    i_op.valid <= 1'b0;
    #1;
    chk("op", {6'h0, o_op_grant, o_op_refuse}, {6'h0, !prot, prot});
  endtask

  task automatic step(input int msk);
    int s;
    s = rnd() & 7;
    if ((rnd() & 7) == 0)
    begin
      @(posedge i_clk);
      i_wp_n <= rnd() & 1;
      repeat (3) @(posedge i_clk);
    end
    cmd(codes[rnd() & 3], s, rnd() & (s == 2 ? msk : 255), rnd() & msk, rnd() & 1);
    op((rnd() & 255) % 3, rnd() & 24'hFFFFFF);
  endtask

  initial
  begin
    st = 0;
    lv = 0;
    cf = 0;
    cl = 0;
    rd = 0;
    repeat (2) @(posedge i_clk);
    i_nrst <= 1'b1;
    #1;
    chk("stored", o_status_stored, 8'h00);
    chk("live", o_status_live, 8'h00);
    // Random traffic with the select bit held clear
    for (int i = 0; i < 150; i++) step(8'hF7);
    $display("test select clear done");
    // Switch protection to the live field, then random traffic again
    @(posedge i_clk);
    i_wp_n <= 1'b1;
    repeat (3) @(posedge i_clk);
    cmd(8'h71, 2, 8'h08, 0, 1'b0);
    for (int i = 0; i < 150; i++) step(8'hFF);
    $display("test select set done");
    // Reload copies stored contents into the live registers
    @(posedge i_clk);
    i_reload <= 1'b1;
    @(posedge i_clk);
    i_reload <= 1'b0;
    #1;
    lv = st;
    cl = cf;
    chk("live", o_status_live, 8'(lv));
    chk("config", o_config_live, 8'(cl));
    $display("test reload done");
    results();
  end
endmodule
